// >>> core/asu_params.svh
// register indices, address width, field positions and codes of the serial port
// assumes word-indexed registers: byte address is four times the index
`ifndef ASU_PARAMS_SVH
`define ASU_PARAMS_SVH

`define ASU_ADDR_W 18
`define ASU_IDX_STATUS 16'hfe00
`define ASU_IDX_DATA_LO 16'hfe01
`define ASU_IDX_DATA_HI 16'hfe02
`define ASU_IDX_DIV 16'hfe03
`define ASU_IDX_IRQ_STAT 16'hfe04
`define ASU_IDX_IRQ_MASK 16'hfe05

`define ASU_ST_FRAMERR 4
`define ASU_ST_RXORUN 3
`define ASU_ST_RXFULL 2
`define ASU_ST_TXFULL 1
`define ASU_ST_TXRUN 0

`define ASU_DIV_RESET 16'h0000
`define ASU_DATA_BITS 3'h7
`define ASU_FRAME_LAST 4'h9

`define ASU_IRQ_W 4
`define ASU_IRQ_RX 0
`define ASU_IRQ_TX 1
`define ASU_IRQ_FERR 2
`define ASU_IRQ_ORUN 3

`define ASU_RESP_OKAY 2'h0
`define ASU_RESP_SLVERR 2'h2

`endif

// >>> core/asu_pkg.sv
// types shared by the serial port files
// assumes nothing of its surroundings
package asu_pkg;

    typedef enum logic [1:0] {
        rx_idle,
        rx_start,
        rx_data,
        rx_stop
    } asu_rx_state_type;

endpackage : asu_pkg

// >>> core/asu_sync.sv
// two-flop synchroniser for one level
// assumes d_i is asynchronous to clk_i
`timescale 1ns/1ps

module asu_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // level
    input wire logic d_i,
    output logic q_o
);

    logic meta;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end

endmodule : asu_sync

// >>> core/asu_bit_timer.sv
// two-stage bit timer: prescale by d1+1, then count d2 prescaled steps
// assumes d1/d2 are held stable by software while a frame runs
`timescale 1ns/1ps

module asu_bit_timer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic run_i,
    input wire logic restart_i,
    input wire logic [7:0] d1_i,
    input wire logic [7:0] d2_i,
    // ticks
    output logic bit_tick_o,
    output logic mid_tick_o
);

    logic [7:0] pre;
    logic [7:0] cnt;

    wire pre_wrap = run_i && !restart_i && (pre == d1_i);
    wire cnt_last = (cnt == d2_i - 8'h01);
    wire cnt_mid = (cnt == {1'b0, d2_i[7:1]});

    // d2 of zero stalls the timer instead of ticking every 256 prescale steps
    assign bit_tick_o = pre_wrap && cnt_last && (d2_i != 8'h00);
    assign mid_tick_o = pre_wrap && cnt_mid && (d2_i != 8'h00);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre <= 8'h00;
            cnt <= 8'h00;
        end else if (restart_i || !run_i) begin
            pre <= 8'h00;
            cnt <= 8'h00;
        end else begin
            pre <= pre_wrap ? 8'h00 : pre + 8'h01;
            if (pre_wrap) begin
                cnt <= cnt_last ? 8'h00 : cnt + 8'h01;
            end
        end
    end

endmodule : asu_bit_timer

// >>> core/asu_uart_top.sv
// serial port: byte transmitter and receiver behind an AXI4-Lite register slave
// assumes one write and one read at most outstanding; rx_i is asynchronous
//
// Overview of operation
// - transmit line rests high between frames; receiver treats steady high as idle.
// - frame is low start, eight data bits LSB first, high stop: ten bits.
// - line sampled at stop bit; low sets the framing error flag, status bit 4.
// - on byte transfer, overrun flag bit 3 set if unread data lost, else cleared.
// - receive-full flag bit 2 high while received byte remains unread.
// - data read gives byte in 7:0, zero above; read clears receive-full.
// - receive interrupt request on every byte moved into the receive data register.
// - transmit-full flag bit 1 high while the transmit data register is occupied.
// - transmitter-running flag bit 0 high while a frame shifts out.
// - data write sends bits 7:0; idle transmitter loads, interrupts and starts at once.
// - busy transmitter: byte held, transmit-full set, loaded when the frame ends.
// - high data register behaves the same, with the byte in bits 15:8.
// - divider register: first divider 15:8, second 7:0, reset to zero.
// - bit rate is clock divided by (first divider plus one) times second divider.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "asu_params.svh"

module asu_uart_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // axi4-lite write address and data
    input wire logic [`ASU_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read
    input wire logic [`ASU_ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // serial line
    input wire logic rx_i,
    output logic tx_o,
    // interrupts
    output logic rx_irq_o,
    output logic tx_irq_o,
    output logic irq_o
);

    // write channel capture
    logic aw_held;
    logic w_held;
    logic [`ASU_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // registers
    logic [15:0] baud_divider;
    logic [`ASU_IRQ_W-1:0] irq_stat;
    logic [`ASU_IRQ_W-1:0] irq_mask;

    // transmitter
    logic [9:0] tx_shift;
    logic [3:0] tx_cnt;
    logic [7:0] tx_hold;
    logic tx_full_flag;
    logic tx_running_flag;

    // receiver
    asu_pkg::asu_rx_state_type rx_state;
    logic rx_s;
    logic rx_prev;
    logic [7:0] rx_shift;
    logic [2:0] rx_cnt;
    logic [7:0] rx_data;
    logic rx_full_flag;
    logic rx_overrun_flag;
    logic framing_error_flag;

    // bus handshakes and decode
    wire aw_fire = s_axi_awvalid_i && s_axi_awready_o;
    wire w_fire = s_axi_wvalid_i && s_axi_wready_o;
    wire ar_fire = s_axi_arvalid_i && s_axi_arready_o;
    wire wr_go = aw_held && w_held && !s_axi_bvalid_o;
    wire next_aw_held = aw_fire || (aw_held && !wr_go);
    wire next_w_held = w_fire || (w_held && !wr_go);
    wire next_rvalid = ar_fire || (s_axi_rvalid_o && !s_axi_rready_i);

    wire [15:0] wr_idx = aw_addr[`ASU_ADDR_W-1:2];
    wire [15:0] rd_idx = s_axi_araddr_i[`ASU_ADDR_W-1:2];

    wire wr_status = (wr_idx == `ASU_IDX_STATUS);
    wire wr_lo = (wr_idx == `ASU_IDX_DATA_LO);
    wire wr_hi = (wr_idx == `ASU_IDX_DATA_HI);
    wire wr_div = (wr_idx == `ASU_IDX_DIV);
    wire wr_istat = (wr_idx == `ASU_IDX_IRQ_STAT);
    wire wr_imask = (wr_idx == `ASU_IDX_IRQ_MASK);
    wire wr_mapped = wr_status || wr_lo || wr_hi || wr_div || wr_istat || wr_imask;

    wire rd_status = (rd_idx == `ASU_IDX_STATUS);
    wire rd_lo = (rd_idx == `ASU_IDX_DATA_LO);
    wire rd_hi = (rd_idx == `ASU_IDX_DATA_HI);
    wire rd_div = (rd_idx == `ASU_IDX_DIV);
    wire rd_istat = (rd_idx == `ASU_IDX_IRQ_STAT);
    wire rd_imask = (rd_idx == `ASU_IDX_IRQ_MASK);
    wire rd_mapped = rd_status || rd_lo || rd_hi || rd_div || rd_istat || rd_imask;

    // a data read consumes the received byte
    wire rd_clear = ar_fire && (rd_lo || rd_hi);

    wire [4:0] line_status = {framing_error_flag, rx_overrun_flag, rx_full_flag,
                              tx_full_flag, tx_running_flag};

    wire [31:0] rd_word =
        rd_status ? {27'h0, line_status} :
        rd_lo ? {24'h0, rx_data} :
        rd_hi ? {16'h0, rx_data, 8'h00} :
        rd_div ? {16'h0, baud_divider} :
        rd_istat ? {28'h0, irq_stat} :
        rd_imask ? {28'h0, irq_mask} : 32'h0;

    // transmitter control
    wire tx_bit_tick;
    wire tx_wr = wr_go && ((wr_lo && w_strb[0]) || (wr_hi && w_strb[1]));
    wire [7:0] tx_byte = wr_hi ? w_data[15:8] : w_data[7:0];
    wire tx_load_now = tx_wr && !tx_running_flag && !tx_full_flag;
    wire tx_keep = tx_wr && tx_running_flag && !tx_full_flag;
    wire tx_reload = tx_full_flag && !tx_running_flag;
    wire tx_load = tx_load_now || tx_reload;
    wire [7:0] tx_load_byte = tx_load_now ? tx_byte : tx_hold;
    wire tx_last = tx_running_flag && tx_bit_tick && (tx_cnt == `ASU_FRAME_LAST);

    // receiver control
    wire rx_mid_tick;
    wire rx_start_det = (rx_state == asu_pkg::rx_idle) && rx_prev && !rx_s;
    wire rx_xfer = (rx_state == asu_pkg::rx_stop) && rx_mid_tick;
    wire orun_ev = rx_xfer && rx_full_flag && !rd_clear;
    wire ferr_ev = rx_xfer && !rx_s;

    // interrupt status, write one to clear, a new event wins
    wire [`ASU_IRQ_W-1:0] irq_ev = {orun_ev, ferr_ev, tx_load, rx_xfer};
    wire [`ASU_IRQ_W-1:0] irq_clr =
        (wr_go && wr_istat && w_strb[0]) ? w_data[`ASU_IRQ_W-1:0] : {`ASU_IRQ_W{1'b0}};

    asu_bit_timer u_tx_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(tx_running_flag),
        .restart_i(tx_load),
        .d1_i(baud_divider[15:8]),
        .d2_i(baud_divider[7:0]),
        .bit_tick_o(tx_bit_tick),
        .mid_tick_o()
    );

    asu_bit_timer u_rx_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(rx_state != asu_pkg::rx_idle),
        .restart_i(rx_start_det),
        .d1_i(baud_divider[15:8]),
        .d2_i(baud_divider[7:0]),
        .bit_tick_o(),
        .mid_tick_o(rx_mid_tick)
    );

    asu_sync #(
        .RST_VAL(1'b1)
    ) u_rx_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(rx_i),
        .q_o(rx_s)
    );

    // write side of the bus slave
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `ASU_RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            s_axi_awready_o <= !next_aw_held;
            s_axi_wready_o <= !next_w_held;
            if (aw_fire) begin
                aw_addr <= s_axi_awaddr_i;
            end
            if (w_fire) begin
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            if (wr_go) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_mapped ? `ASU_RESP_OKAY : `ASU_RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // read side of the bus slave
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0;
            s_axi_rresp_o <= `ASU_RESP_OKAY;
        end else begin
            s_axi_arready_o <= !next_rvalid;
            s_axi_rvalid_o <= next_rvalid;
            if (ar_fire) begin
                s_axi_rdata_o <= rd_word;
                s_axi_rresp_o <= rd_mapped ? `ASU_RESP_OKAY : `ASU_RESP_SLVERR;
            end
        end
    end

    // divider and interrupt registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            baud_divider <= `ASU_DIV_RESET;
            irq_stat <= '0;
            irq_mask <= '0;
            irq_o <= 1'b0;
        end else begin
            if (wr_go && wr_div && w_strb[0]) begin
                baud_divider[7:0] <= w_data[7:0];
            end
            if (wr_go && wr_div && w_strb[1]) begin
                baud_divider[15:8] <= w_data[15:8];
            end
            if (wr_go && wr_imask && w_strb[0]) begin
                irq_mask <= w_data[`ASU_IRQ_W-1:0];
            end
            irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
            irq_o <= |(irq_stat & irq_mask);
        end
    end

    // transmitter: idle shifter is all ones so the line rests high
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_shift <= 10'h3ff;
            tx_cnt <= 4'h0;
            tx_running_flag <= 1'b0;
            tx_o <= 1'b1;
            tx_irq_o <= 1'b0;
        end else begin
            tx_irq_o <= tx_load;
            tx_o <= tx_shift[0];
            if (tx_load) begin
                tx_shift <= {1'b1, tx_load_byte, 1'b0};
                tx_cnt <= 4'h0;
                tx_running_flag <= 1'b1;
            end else if (tx_running_flag && tx_bit_tick) begin
                tx_shift <= {1'b1, tx_shift[9:1]};
                tx_cnt <= tx_cnt + 4'h1;
                if (tx_last) begin
                    tx_running_flag <= 1'b0;
                end
            end
        end
    end

    // holding register; a write while it is occupied is dropped
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_hold <= 8'h00;
            tx_full_flag <= 1'b0;
        end else if (tx_keep) begin
            tx_hold <= tx_byte;
            tx_full_flag <= 1'b1;
        end else if (tx_reload) begin
            tx_full_flag <= 1'b0;
        end
    end

    // receiver sequencing on mid-bit ticks
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_state <= asu_pkg::rx_idle;
            rx_prev <= 1'b1;
            rx_shift <= 8'h00;
            rx_cnt <= 3'h0;
        end else begin
            rx_prev <= rx_s;
            unique case (rx_state)
                asu_pkg::rx_idle: begin
                    if (rx_start_det) begin
                        rx_state <= asu_pkg::rx_start;
                    end
                end
                asu_pkg::rx_start: begin
                    if (rx_mid_tick) begin
                        // a glitch shorter than half a bit is not a start
                        rx_state <= rx_s ? asu_pkg::rx_idle : asu_pkg::rx_data;
                        rx_cnt <= 3'h0;
                    end
                end
                asu_pkg::rx_data: begin
                    if (rx_mid_tick) begin
                        rx_shift <= {rx_s, rx_shift[7:1]};
                        rx_cnt <= rx_cnt + 3'h1;
                        if (rx_cnt == `ASU_DATA_BITS) begin
                            rx_state <= asu_pkg::rx_stop;
                        end
                    end
                end
                asu_pkg::rx_stop: begin
                    if (rx_mid_tick) begin
                        rx_state <= asu_pkg::rx_idle;
                    end
                end
            endcase
        end
    end

    // receive data register and its flags
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_data <= 8'h00;
            rx_full_flag <= 1'b0;
            rx_overrun_flag <= 1'b0;
            framing_error_flag <= 1'b0;
            rx_irq_o <= 1'b0;
        end else begin
            rx_irq_o <= rx_xfer;
            if (rx_xfer) begin
                rx_data <= rx_shift;
                rx_full_flag <= 1'b1;
                rx_overrun_flag <= orun_ev;
                framing_error_flag <= !rx_s;
            end else if (rd_clear) begin
                rx_full_flag <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_tx_idle_high: assert property (!tx_running_flag && !$past(tx_running_flag)
                                     |-> tx_o)
        else $error("transmit line low while idle");
    a_tx_start_bit: assert property (tx_load |=> ##1 !tx_o)
        else $error("frame did not open with a low start bit");
    a_tx_stop_bit: assert property (tx_last |-> ##1 tx_o)
        else $error("stop bit not high");
    a_rx_ferr_flag: assert property (rx_xfer |=> framing_error_flag == !$past(rx_s))
        else $error("framing error flag does not follow stop bit");
    a_rx_ovr_flag: assert property (rx_xfer && !rd_clear
                                    |=> rx_overrun_flag == $past(rx_full_flag))
        else $error("overrun flag wrong after transfer");
    a_rx_full_set: assert property (rx_xfer |=> rx_full_flag
                                    ##1 (rx_full_flag || $past(rd_clear)))
        else $error("receive full not held after transfer");
    a_rd_data_zero: assert property (ar_fire && rd_lo && !rx_xfer
                                     |=> s_axi_rdata_o[31:8] == 24'h0 && !rx_full_flag)
        else $error("data read returned upper bits or kept full");
    a_rx_irq_pulse: assert property (rx_xfer |=> rx_irq_o ##1 !rx_irq_o)
        else $error("receive interrupt not a single pulse");
    a_tx_full_busy: assert property (tx_full_flag && !tx_running_flag
                                     |=> tx_running_flag && !tx_full_flag)
        else $error("held byte not loaded after frame end");
    a_tx_load_run: assert property (tx_load |=> tx_running_flag && tx_irq_o)
        else $error("load did not start transmitter and interrupt");
    a_tx_keep_full: assert property (tx_keep |=> tx_full_flag && tx_hold == $past(tx_byte))
        else $error("busy write not held");

    c_rx_byte: cover property (rx_xfer);
    c_tx_queued: cover property (tx_reload);
    c_rx_ferr: cover property (ferr_ev);
    c_rx_orun: cover property (orun_ev);

endmodule : asu_uart_top

// >>> test/asu_peer.sv
// serial peer: sends frames on the receive line, captures frames from the transmit line
// assumes the bench sets bitc to the bit period in clocks before any traffic
`timescale 1ns/1ps

module asu_peer (
    // clock
    input wire logic clk_i,
    // serial lines
    input wire logic tx_line_i,
    output logic rx_line_o
);
    int bitc = 6;
    logic [9:0] got [$];

    // a steady high line is idle
    initial rx_line_o = 1'b1;

    // start low, lsb first, stop bit as asked; stop low makes a break-like frame
    task automatic send(input logic [7:0] b, input logic stp);
        logic [9:0] f;
        f = {stp, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_line_o <= f[i];
            repeat (bitc) @(posedge clk_i);
        end
        rx_line_o <= 1'b1;
        repeat (2 * bitc) @(posedge clk_i);
    endtask : send

    // short low pulse: must die at the mid-bit check, no byte may follow
    task automatic glitch();
        rx_line_o <= 1'b0;
        repeat (bitc / 3) @(posedge clk_i);
        rx_line_o <= 1'b1;
        repeat (12 * bitc) @(posedge clk_i);
    endtask : glitch

    // sample at bit centres; stops at the stop bit so a quick next start is not lost
    always begin : catch_frame
        logic [9:0] s;
        @(negedge tx_line_i);
        repeat (bitc / 2) @(posedge clk_i);
        for (int i = 0; i < 10; i++) begin
            s[i] = tx_line_i;
            if (i < 9) repeat (bitc) @(posedge clk_i);
        end
        got.push_back(s);
    end
endmodule : asu_peer

// >>> test/async_serial_uart_tb.sv
// bench for the serial port: axi4-lite master, register model, serial peer
// assumes the peer bit period is set to match the divider that was written
`timescale 1ns/1ps
`include "asu_params.svh"

module async_serial_uart_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [17:0] s_axi_awaddr_i = '0;
    logic [17:0] s_axi_araddr_i = '0;
    logic [31:0] s_axi_wdata_i = '0;
    logic [3:0] s_axi_wstrb_i = '0;
    logic s_axi_awvalid_i = 1'b0;
    logic s_axi_wvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0;
    logic s_axi_rready_i = 1'b0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    logic rx_i, tx_o, rx_irq_o, tx_irq_o, irq_o;
    int errors = 0, n_checks = 0, bitc, n_rx = 0, n_tx = 0, m_rx = 0, m_tx = 0;
    logic [31:0] seed = 32'd388;
    logic m_full = 1'b0, m_orun = 1'b0, m_ferr = 1'b0;
    logic [3:0] m_irq = 4'h0;

    always #50 clk_i = ~clk_i;

    asu_uart_top asu_uart_top_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i),
        .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
        .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
        .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
        .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
        .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
        .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
        .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
        .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
        .s_axi_rready_i(s_axi_rready_i), .rx_i(rx_i), .tx_o(tx_o),
        .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o), .irq_o(irq_o)
    );

    asu_peer asu_peer_inst (.clk_i(clk_i), .tx_line_i(tx_o), .rx_line_o(rx_i));

    // a pulse longer than one cycle counts once per cycle and shows up as a mismatch
    always @(posedge clk_i) begin
        if (rx_irq_o === 1'b1) n_rx++;
        if (tx_irq_o === 1'b1) n_tx++;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic logic [17:0] ad(input logic [15:0] i);
        return {i, 2'b00};
    endfunction : ad

    function automatic logic [31:0] st(input logic txf, input logic txr);
        return {27'h0, m_ferr, m_orun, m_full, txf, txr};
    endfunction : st

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_wstrb_i <= s;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge clk_i);
            if (!ta && s_axi_awready_o === 1'b1) begin
                ta = 1'b1;
                s_axi_awvalid_i <= 1'b0;
            end
            if (!tw && s_axi_wready_o === 1'b1) begin
                tw = 1'b1;
                s_axi_wvalid_i <= 1'b0;
            end
        end
        s_axi_bready_i <= 1'b1;
        @(posedge clk_i);
        while (s_axi_bvalid_o !== 1'b1) @(posedge clk_i);
        r = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        @(posedge clk_i);
        while (s_axi_arready_o !== 1'b1) @(posedge clk_i);
        s_axi_arvalid_i <= 1'b0;
        s_axi_rready_i <= 1'b1;
        @(posedge clk_i);
        while (s_axi_rvalid_o !== 1'b1) @(posedge clk_i);
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
    endtask : rd

    task automatic rx_byte(input logic [7:0] b, input logic stp);
        asu_peer_inst.send(b, stp);
        m_orun = m_full;
        m_full = 1'b1;
        m_ferr = ~stp;
        m_rx++;
        m_irq |= {m_orun, ~stp, 2'b01};
    endtask : rx_byte

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    initial begin : main
        logic [31:0] d;
        logic [31:0] v;
        logic [1:0] r;
        logic [7:0] b [3];
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(ad(`ASU_IDX_DIV), d, r);
        chk("div reset", d, `ASU_DIV_RESET);
        rd(ad(`ASU_IDX_STATUS), d, r);
        chk("status reset", d, st(1'b0, 1'b0));
        chk("tx idle", tx_o, 1'b1);
        for (int c = 0; c < 2; c++) begin
            v = c ? 32'h0107 : 32'h0006;
            bitc = (v[15:8] + 1) * v[7:0];
            asu_peer_inst.bitc = bitc;
            wr(ad(`ASU_IDX_DIV), v, 4'h3, r);
            rd(ad(`ASU_IDX_DIV), d, r);
            chk("divider", d, v);
            v = xs();
            b[0] = v[7:0];
            b[1] = v[15:8];
            d = xs();
            d[7:0] = b[0];
            wr(ad(`ASU_IDX_DATA_LO), d, 4'hf, r);
            wr(ad(`ASU_IDX_DATA_HI), {16'h0, b[1], 8'h0}, 4'h2, r);
            m_tx += 2;
            m_irq |= 4'h2;
            rd(ad(`ASU_IDX_STATUS), d, r);
            chk("tx busy status", d, st(1'b1, 1'b1));
            while (asu_peer_inst.got.size() < 2) @(posedge clk_i);
            for (int i = 0; i < 2; i++) begin
                chk("tx frame", asu_peer_inst.got.pop_front(), {1'b1, b[i], 1'b0});
            end
            repeat (bitc) @(posedge clk_i);
            rd(ad(`ASU_IDX_STATUS), d, r);
            chk("tx done status", d, st(1'b0, 1'b0));
            chk("tx idle", tx_o, 1'b1);
            asu_peer_inst.glitch();
            chk("glitch ignored", n_rx, m_rx);
            for (int i = 0; i < 3; i++) begin
                v = xs();
                b[i] = v[7:0];
                rx_byte(b[i], i != 2);
                if (i == 0) begin
                    rd(ad(`ASU_IDX_STATUS), d, r);
                    chk("rx full", d, st(1'b0, 1'b0));
                    rd(ad(`ASU_IDX_DATA_LO), d, r);
                    m_full = 1'b0;
                    chk("rx data", d, {24'h0, b[0]});
                    rd(ad(`ASU_IDX_STATUS), d, r);
                    chk("rx read clears", d, st(1'b0, 1'b0));
                end
            end
            rd(ad(`ASU_IDX_STATUS), d, r);
            chk("rx errors", d, st(1'b0, 1'b0));
            rd(ad(`ASU_IDX_DATA_HI), d, r);
            m_full = 1'b0;
            chk("rx data high", d, {16'h0, b[2], 8'h0});
            rd(ad(`ASU_IDX_IRQ_STAT), d, r);
            chk("irq status", d, {28'h0, m_irq});
            chk("rx pulses", n_rx, m_rx);
            chk("tx pulses", n_tx, m_tx);
            wr(ad(`ASU_IDX_IRQ_MASK), c ? 32'hf : 32'h0, 4'h1, r);
            repeat (3) @(posedge clk_i);
            chk("irq level", irq_o, c);
            wr(ad(`ASU_IDX_IRQ_STAT), 32'hf, 4'h1, r);
            m_irq = 4'h0;
            repeat (3) @(posedge clk_i);
            chk("irq cleared", irq_o, 1'b0);
            rd(ad(`ASU_IDX_IRQ_STAT), d, r);
            chk("irq status cleared", d, {28'h0, m_irq});
        end
        // unmapped place and read-only status
        rd(ad(16'hfe06), d, r);
        chk("unmapped rdata", d, 32'h0);
        chk("unmapped rresp", r, `ASU_RESP_SLVERR);
        wr(ad(16'hfe06), 32'hff, 4'hf, r);
        chk("unmapped bresp", r, `ASU_RESP_SLVERR);
        wr(ad(`ASU_IDX_STATUS), 32'h1f, 4'hf, r);
        rd(ad(`ASU_IDX_STATUS), d, r);
        chk("status read only", d, st(1'b0, 1'b0));
        end_sim();
    end

    // whole run is under two thousand cycles; this leaves ample margin
    initial begin : watchdog
        repeat (20000) @(posedge clk_i);
        errors++;
        end_sim();
    end
endmodule : async_serial_uart_tb
